//--- verilog/ssv_pkg.sv
// Package for the status, stack and interrupt vectoring block.
// Assumes one core clock and an 8-bit data path; shared by both ends.
package ssv_pkg;
   // -----------------------------------------------------------------
   // Register space
   // -----------------------------------------------------------------
   localparam logic [5:0] IO_STATUS      = 6'h3F; // Processor status
   localparam logic [5:0] IO_STACK       = 6'h3D; // Stack pointer
   localparam logic [5:0] IO_BIT_TOP     = 6'h1F; // Last bit-accessible address
   localparam logic [7:0] DATA_IO_OFFSET = 8'h20; // Data-space alias offset
   localparam logic [7:0] DATA_IO_LAST   = 8'h5F; // Last aliased data address
   localparam logic [7:0] STATUS_RESET   = 8'h00; // Status reset value
   localparam logic [7:0] STACK_RESET    = 8'h00; // Stack reset value
   localparam logic [7:0] STACK_LOW      = 8'h60; // Bottom of data memory
   // -----------------------------------------------------------------
   // Status bit positions
   // -----------------------------------------------------------------
   localparam int BIT_I = 7; // Global interrupt enable
   localparam int BIT_T = 6; // Transfer store
   localparam int BIT_H = 5; // Half carry
   localparam int BIT_S = 4; // Sign
   localparam int BIT_V = 3; // Overflow
   localparam int BIT_N = 2; // Negative
   localparam int BIT_Z = 1; // Zero
   localparam int BIT_C = 0; // Carry
   // -----------------------------------------------------------------
   // Vectors and stack steps
   // -----------------------------------------------------------------
   localparam logic [9:0] VEC_RESET = 10'h000; // Reset vector
   localparam logic [9:0] VEC_EXT   = 10'h001; // External request vector
   localparam logic [9:0] VEC_TIMER = 10'h002; // Timer overflow vector
   localparam logic [7:0] STEP_DATA = 8'h01;   // Data push/pop step
   localparam logic [7:0] STEP_ADDR = 8'h02;   // Return address step
   localparam int ENTRY_CYCLES = 4;            // Cycles from flag to vector
   localparam logic [2:0] ENTRY_LAST = 3'h3;   // Last count of entry
   // Stack operations requested by the core
   typedef enum logic [2:0] {
      SOP_NONE, SOP_PUSH, SOP_POP, SOP_CALL, SOP_RET, SOP_RETURN_FROM_INTERRUPT
   } ssv_stack_op_e;
   // Bit operations on the register space
   typedef enum logic [1:0] {
      BOP_NONE, BOP_SET, BOP_CLEAR, BOP_TEST
   } ssv_bit_op_e;
endpackage : ssv_pkg

//--- verilog/ssv_if.sv
// Interface joining the execution core end and the status/vector end.
// Assumes both ends share clk; the core is master of every request.
`timescale 1ns/1ps
interface ssv_if
   import ssv_pkg::*;
   ();
   logic          ioWr;      // Register write strobe
   logic          ioRd;      // Register read strobe
   logic [7:0]    ioAddr;    // Register index or data-space address
   logic          ioData;    // 1: address is data-space alias
   logic [7:0]    ioWdata;   // Write data
   logic [7:0]    ioRdata;   // Read data (registered)
   logic          ioHit;     // Address belongs to this block
   ssv_bit_op_e   bitOp;     // Single-bit operation
   logic [2:0]    bitSel;    // Bit number for bit operation
   logic          bitDone;   // Bit op complete, one cycle
   logic          bitSkip;   // Test result: skip next
   logic          bitRefused;// Bit op outside low half
   ssv_stack_op_e stackOp;   // Stack pointer operation
   logic [7:0]    stackPtr;  // Current stack pointer
   logic          aluWe;     // Arithmetic flag update strobe
   logic [4:0]    aluFlags;  // H,V,N,Z,C new values
   logic          tStore;    // Bit-store: load T
   logic          tValue;    // Bit value for T
   logic          tFlag;     // T for bit-load
   logic          instrEnd;  // Core finished an instruction
   logic          irqTake;   // Interrupt accepted, one cycle
   logic [9:0]    irqVector; // Vector address
   logic          irqAck0;   // External flag served
   logic          irqAck1;   // Timer flag served
   modport status (
      input  ioWr, ioRd, ioAddr, ioData, ioWdata, bitOp, bitSel, stackOp,
             aluWe, aluFlags, tStore, tValue, instrEnd,
      output ioRdata, ioHit, bitDone, bitSkip, bitRefused, stackPtr, tFlag,
             irqTake, irqVector, irqAck0, irqAck1
   );
   modport core (
      output ioWr, ioRd, ioAddr, ioData, ioWdata, bitOp, bitSel, stackOp,
             aluWe, aluFlags, tStore, tValue, instrEnd,
      input  ioRdata, ioHit, bitDone, bitSkip, bitRefused, stackPtr, tFlag,
             irqTake, irqVector, irqAck0, irqAck1
   );
endinterface : ssv_if

//--- verilog/ssv_irq_arb.sv
// Fixed-priority interrupt arbiter with entry delay and return guard.
// Assumes request levels come from flip-flops on the same clock.
`timescale 1ns/1ps
module ssv_irq_arb
   import ssv_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       globalEn,   // Status bit 7
   input  wire logic [1:0] req,        // [0] external, [1] timer, enabled
   input  wire logic       instrEnd,   // Instruction boundary
   input  wire logic       retiSeen,   // Return from interrupt executed
   output logic            take,       // Accept pulse
   output logic [9:0]      vector,     // Chosen vector
   output logic [1:0]      ack         // Which source was served
);
   // -----------------------------------------------------------------
   // Pending age and return guard
   // -----------------------------------------------------------------
   logic [2:0] age_q, age_d;      // Cycles since a request seen
   logic       guard_q, guard_d;  // One main instruction after return
   logic [9:0] vector_q, vector_d;
   logic       any;
   // Next state of arbiter
   always_comb begin
      any      = globalEn && (req != 2'b00);
      age_d    = age_q;
      guard_d  = guard_q;
      vector_d = vector_q;
      take     = 1'b0;
      ack      = 2'b00;
      if (!any) begin
         age_d = 3'h0;
      end else if (age_q != ENTRY_LAST) begin
         age_d = age_q + 3'h1;
      end
      if (retiSeen) begin
         guard_d = 1'b1;
      end else if (instrEnd) begin
         guard_d = 1'b0;
      end
      // Only at a boundary, so multi-cycle instructions finish first
      if (any && instrEnd && !guard_q && age_q == ENTRY_LAST) begin
         take  = 1'b1;
         age_d = 3'h0;
         if (req[0]) begin
            ack      = 2'b01;
            vector_d = VEC_EXT;
         end else begin
            ack      = 2'b10;
            vector_d = VEC_TIMER;
         end
      end
   end
   // Registers
   always_ff @(posedge clk) begin
      if (rst) begin
         age_q    <= 3'h0;
         guard_q  <= 1'b0;
         vector_q <= VEC_RESET;
      end else begin
         age_q    <= age_d;
         guard_q  <= guard_d;
         vector_q <= vector_d;
      end
   end
   assign vector = vector_d;
endmodule : ssv_irq_arb

//--- verilog/ssv_status_end.sv
// Status register, stack pointer and interrupt vectoring end.
// Assumes the core end drives requests synchronously on clk.
`timescale 1ns/1ps
module ssv_status_end
   import ssv_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   ssv_if.status     bus,
   input  wire logic extReq,    // External request flag level
   input  wire logic extEn,     // External request enable
   input  wire logic timerReq,  // Timer overflow flag level
   input  wire logic timerEn,   // Timer overflow enable
   output logic [7:0] statusOut // Processor status to user side
);
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [7:0] status_q, status_d;  // Processor status
   logic [7:0] sp_q, sp_d;          // Stack pointer
   logic [7:0] rdata_q, rdata_d;    // Registered read data
   logic       done_q, done_d;      // Bit op done
   logic       skip_q, skip_d;      // Test result
   logic       refused_q, refused_d;
   // Decode and arbiter wiring
   logic [5:0] idx;                 // Register index
   logic       inRange;             // Address maps to register space
   logic       take;
   logic [9:0] vec;
   logic [1:0] ack;
   logic [7:0] cur;                 // Register read before bit op
   logic [7:0] mod;
   logic       retiSeen;
   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   // Both forms fold onto one 6-bit index
   // Out-of-range reads and writes are ignored; bit ops there are refused
   always_comb begin
      // Alias sits 0x20 above the register index
      if (bus.ioData) begin
         inRange = (bus.ioAddr >= DATA_IO_OFFSET) && (bus.ioAddr <= DATA_IO_LAST);
         idx     = 6'(bus.ioAddr - DATA_IO_OFFSET);
      end else begin
         inRange = (bus.ioAddr[7:6] == 2'b00);
         idx     = bus.ioAddr[5:0];
      end
   end
   // Hit is informational for the core
   assign bus.ioHit = inRange && (idx == IO_STATUS || idx == IO_STACK);
   // Return arms the one-instruction guard
   assign retiSeen  = (bus.stackOp == SOP_RETURN_FROM_INTERRUPT);
   // -----------------------------------------------------------------
   // Arbiter
   // -----------------------------------------------------------------
   // Enables gate requests here; global
   // enable goes in apart so age counts
   // only while a take is possible
   ssv_irq_arb ssv_irq_arb_inst (
      .clk      (clk),
      .rst      (rst),
      .globalEn (status_q[BIT_I]),
      .req      ({timerReq && timerEn, extReq && extEn}),
      .instrEnd (bus.instrEnd),
      .retiSeen (retiSeen),
      .take     (take),
      .vector   (vec),
      .ack      (ack)
   );
   // -----------------------------------------------------------------
   // Status, stack and register access next state
   // -----------------------------------------------------------------
   // One process for all state of this end,
   // so competing writers resolve in fixed
   // order: later statements win
   always_comb begin
      // Defaults hold status, pointer and read data; done, skip and refused clear
      status_d  = status_q;
      sp_d      = sp_q;
      rdata_d   = rdata_q;
      done_d    = 1'b0;
      skip_d    = 1'b0;
      refused_d = 1'b0;
      cur       = 8'h00;
      mod       = 8'h00;
      // Arithmetic flags land at fixed positions
      // Flag update comes from the ALU strobe
      if (bus.aluWe) begin
         status_d[BIT_H] = bus.aluFlags[4];
         status_d[BIT_V] = bus.aluFlags[3];
         status_d[BIT_N] = bus.aluFlags[2];
         status_d[BIT_Z] = bus.aluFlags[1];
         status_d[BIT_C] = bus.aluFlags[0];
      end
      // Bit-store loads T only
      if (bus.tStore) begin
         status_d[BIT_T] = bus.tValue;
      end
      // Register write; the pointer is plain read/write, status takes S from N xor V below
      if (bus.ioWr && inRange) begin
         if (idx == IO_STATUS) status_d = bus.ioWdata;
         if (idx == IO_STACK)  sp_d = bus.ioWdata;
      end
      // Read data stands until next in-range read or completed bit op
      if (bus.ioRd && inRange) begin
         rdata_d = (idx == IO_STATUS) ? status_q :
                   (idx == IO_STACK)  ? sp_q : 8'h00;
      end
      // Bit ops: only low half; whole register read back, modified and returned as read data.
      // Neither register of this block lies there, so hits read as zero.
      if (bus.bitOp != BOP_NONE) begin
         // Alias 0x20-0x3F counts as low half
         if (idx > IO_BIT_TOP || !inRange) begin
            refused_d = 1'b1;
         end else begin
            done_d = 1'b1;
            mod    = cur;
            if (bus.bitOp == BOP_SET)   mod[bus.bitSel] = 1'b1;
            if (bus.bitOp == BOP_CLEAR) mod[bus.bitSel] = 1'b0;
            skip_d = (bus.bitOp == BOP_TEST) && cur[bus.bitSel];
            rdata_d = mod;
         end
      end
      // Pointer wraps modulo 256; no bound
      // check, software keeps it in memory
      // Stack steps; status itself is never stacked
      case (bus.stackOp)
         SOP_PUSH: sp_d = sp_q - STEP_DATA;
         SOP_POP:  sp_d = sp_q + STEP_DATA;
         SOP_CALL: sp_d = sp_q - STEP_ADDR;
         SOP_RET:  sp_d = sp_q + STEP_ADDR;
         SOP_RETURN_FROM_INTERRUPT: begin
            sp_d            = sp_q + STEP_ADDR;
            status_d[BIT_I] = 1'b1;
         end
         // No stack operation
         default: ;
      endcase
      // Accept has priority over a same-cycle stack op
      // (hardware pushes the return address)
      if (take) begin
         sp_d            = sp_q - STEP_ADDR;
         status_d[BIT_I] = 1'b0;
      end
      // Done last, so a direct write cannot
      // leave the sign bit inconsistent
      // Sign always follows N xor V
      status_d[BIT_S] = status_d[BIT_N] ^ status_d[BIT_V];
   end
   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   // Stack reset value is a choice; software
   // loads the pointer before any call
   always_ff @(posedge clk) begin
      if (rst) begin
         status_q  <= STATUS_RESET;
         sp_q      <= STACK_RESET;
         rdata_q   <= 8'h00;
         done_q    <= 1'b0;
         skip_q    <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         status_q  <= status_d;
         sp_q      <= sp_d;
         rdata_q   <= rdata_d;
         done_q    <= done_d;
         skip_q    <= skip_d;
         refused_q <= refused_d;
      end
   end
   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // Accept and acks are comb and stand
   // only in the accept cycle; vector holds after it
   assign bus.ioRdata    = rdata_q;
   assign bus.bitDone    = done_q;
   assign bus.bitSkip    = skip_q;
   assign bus.bitRefused = refused_q;
   assign bus.stackPtr   = sp_q;
   assign bus.tFlag      = status_q[BIT_T];
   assign bus.irqTake    = take;
   assign bus.irqVector  = vec;
   assign bus.irqAck0    = ack[0];
   assign bus.irqAck1    = ack[1];
   // Status copy for the user side
   assign statusOut      = status_q;
endmodule : ssv_status_end

//--- verilog/ssv_core_end.sv
// Execution core end: forwards user-side requests onto the interface.
// Assumes the user side obeys the software duties on stack and reserved bits.
`timescale 1ns/1ps
module ssv_core_end
   import ssv_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst,
   ssv_if.core                bus,
   input  wire logic          uWr,       // Write request
   input  wire logic          uRd,       // Read request
   input  wire logic [7:0]    uAddr,     // Address
   input  wire logic          uData,     // Data-space addressing
   input  wire logic [7:0]    uWdata,    // Write data
   input  wire ssv_bit_op_e   uBitOp,    // Bit operation
   input  wire logic [2:0]    uBitSel,   // Bit number
   input  wire ssv_stack_op_e uStackOp,  // Stack operation
   input  wire logic          uAluWe,    // Flag update
   input  wire logic [4:0]    uAluFlags, // H,V,N,Z,C
   input  wire logic          uTStore,   // Bit-store
   input  wire logic          uTValue,   // Bit value
   input  wire logic          uInstrEnd, // Instruction boundary
   output logic [7:0]         uRdata,    // Read data
   output logic [9:0]         uPc,       // Program counter after vectoring
   output logic               uSkip,     // Skip next instruction
   output logic               uTFlag     // Transfer bit for bit-load
);
   // -----------------------------------------------------------------
   // Request pass-through; register-form writes above 0x3F are dropped
   // -----------------------------------------------------------------
   logic [9:0] pc_q, pc_d;  // Program counter
   assign bus.ioWr     = uWr && (uData || uAddr[7:6] == 2'b00);
   assign bus.ioRd     = uRd;
   assign bus.ioAddr   = uAddr;
   assign bus.ioData   = uData;
   assign bus.ioWdata  = uWdata;
   assign bus.bitOp    = uBitOp;
   assign bus.bitSel   = uBitSel;
   assign bus.stackOp  = uStackOp;
   assign bus.aluWe    = uAluWe;
   assign bus.aluFlags = uAluFlags;
   assign bus.tStore   = uTStore;
   assign bus.tValue   = uTValue;
   assign bus.instrEnd = uInstrEnd;
   // Program counter follows the accepted vector
   always_comb begin
      pc_d = pc_q;
      if (bus.irqTake) pc_d = bus.irqVector;
   end
   always_ff @(posedge clk) begin
      if (rst) pc_q <= VEC_RESET;
      else     pc_q <= pc_d;
   end
   assign uPc    = pc_q;
   assign uRdata = bus.ioRdata;
   assign uSkip  = bus.bitSkip;
   assign uTFlag = bus.tFlag;
endmodule : ssv_core_end

//--- tb/ssv_properties.sv
// Concurrent checks on the status/stack/vector interface signals.
// Assumes it sits beside ssv_if and sees the same clk and rst.
`timescale 1ns/1ps
module ssv_properties
   import ssv_pkg::*;
(
   input wire logic          clk,
   input wire logic          rst,
   input wire logic [7:0]    ioAddr,
   input wire logic          ioData,
   input wire logic [7:0]    ioRdata,
   input wire ssv_bit_op_e   bitOp,
   input wire logic [2:0]    bitSel,
   input wire logic          bitDone,
   input wire logic          bitSkip,
   input wire logic          bitRefused,
   input wire ssv_stack_op_e stackOp,
   input wire logic [7:0]    stackPtr,
   input wire logic          irqTake,
   input wire logic [9:0]    irqVector,
   input wire logic          irqAck0,
   input wire logic          irqAck1
);
   // ----------------------------------------------------------------
   // Defaults: one clock domain, synchronous reset
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic bitLow; // Bit op aimed at the low register half
   logic bitHigh; // Bit op aimed above the low half
   assign bitLow = bitOp != BOP_NONE && !ioData && ioAddr <= 8'h1F;
   assign bitHigh = bitOp != BOP_NONE && !ioData && ioAddr > 8'h1F;
   // ----------------------------------------------------------------
   // Stack pointer arithmetic; an accepted interrupt overrides the op
   // ----------------------------------------------------------------
   data_push_a: assert property (stackOp == SOP_PUSH && !irqTake |=>
      stackPtr == $past(stackPtr) - 8'h01) else $error("push step wrong");
   data_pop_a: assert property (stackOp == SOP_POP && !irqTake |=>
      stackPtr == $past(stackPtr) + 8'h01) else $error("pop step wrong");
   addr_push_a: assert property (stackOp == SOP_CALL || irqTake |=>
      stackPtr == $past(stackPtr) - 8'h02) else $error("call step wrong");
   addr_pop_a: assert property ((stackOp == SOP_RET || stackOp == SOP_RETURN_FROM_INTERRUPT)
      && !irqTake |=> stackPtr == $past(stackPtr) + 8'h02) else $error("return step wrong");
   // ----------------------------------------------------------------
   // Bit operations: low half only, whole modified register returned as read data
   // ----------------------------------------------------------------
   bit_refuse_a: assert property (bitHigh |=> bitRefused && !bitDone)
      else $error("high bit op not refused");
   bit_set_a: assert property (bitLow && bitOp == BOP_SET |=> bitDone &&
      ioRdata == 8'h01 << $past(bitSel)) else $error("bit set result wrong");
   bit_test_a: assert property (bitLow && bitOp == BOP_TEST |=> bitDone
      && !bitSkip && !bitRefused) else $error("bit test result wrong");
   // ----------------------------------------------------------------
   // Interrupt acceptance
   // ----------------------------------------------------------------
   vector_pick_a: assert property (irqTake |-> (irqAck0 ? irqVector == VEC_EXT :
      irqAck1 && irqVector == VEC_TIMER)) else $error("vector or priority wrong");
   ack_take_a: assert property (irqAck0 || irqAck1 |-> irqTake)
      else $error("ack without accept");
   take_pulse_a: assert property (irqTake |=> !irqTake [*2])
      else $error("accept repeated while disabled");
   // Main scenarios reached
   ext_cov: cover property (irqTake && irqAck0);
   tmr_cov: cover property (irqTake && irqAck1);
   ref_cov: cover property (bitRefused);
endmodule : ssv_properties

//--- tb/tb_status_stack_interrupt_vectoring.sv
// Testbench joining both ends of the status/stack/vector block.
// Assumes the design package, interface and both end modules are compiled first.
`timescale 1ns/1ps
module tb_status_stack_interrupt_vectoring
   import ssv_pkg::*;
;
   // ----------------------------------------------------------------
   // Stimulus signals, all given values at time zero
   // ----------------------------------------------------------------
   logic clk = 1'b0, rst = 1'b1; // Clock and sync reset
   logic uWr = 1'b0, uRd = 1'b0, uData = 1'b0, uAluWe = 1'b0; // Strobes
   logic uTStore = 1'b0, uTValue = 1'b0, uInstrEnd = 1'b0; // Flag requests
   logic [7:0] uAddr = 8'h00, uWdata = 8'h00; // Address and data
   logic [2:0] uBitSel = 3'h0; // Bit number
   logic [4:0] uAluFlags = 5'h00; // H,V,N,Z,C
   ssv_bit_op_e uBitOp = BOP_NONE;
   ssv_stack_op_e uStackOp = SOP_NONE;
   logic extReq = 1'b0, extEn = 1'b0, timerReq = 1'b0, timerEn = 1'b0;
   logic [7:0] uRdata, statusOut; // Observed results
   logic [9:0] uPc;
   logic uSkip, uTFlag;
   int errTotal = 0, nTests = 0, cyc = 0, n;
   initial forever #2 clk = ~clk; // 250 MHz
   ssv_if ssv_if_inst ();
   ssv_status_end ssv_status_end_inst (.clk(clk), .rst(rst), .bus(ssv_if_inst),
      .extReq(extReq), .extEn(extEn), .timerReq(timerReq), .timerEn(timerEn),
      .statusOut(statusOut));
   ssv_core_end ssv_core_end_inst (.clk(clk), .rst(rst), .bus(ssv_if_inst),
      .uWr(uWr), .uRd(uRd), .uAddr(uAddr), .uData(uData), .uWdata(uWdata),
      .uBitOp(uBitOp), .uBitSel(uBitSel), .uStackOp(uStackOp), .uAluWe(uAluWe),
      .uAluFlags(uAluFlags), .uTStore(uTStore), .uTValue(uTValue),
      .uInstrEnd(uInstrEnd), .uRdata(uRdata), .uPc(uPc), .uSkip(uSkip), .uTFlag(uTFlag));
   ssv_properties ssv_properties_inst (.clk(clk), .rst(rst), .ioAddr(ssv_if_inst.ioAddr),
      .ioData(ssv_if_inst.ioData), .ioRdata(ssv_if_inst.ioRdata), .bitOp(ssv_if_inst.bitOp),
      .bitSel(ssv_if_inst.bitSel), .bitDone(ssv_if_inst.bitDone),
      .bitSkip(ssv_if_inst.bitSkip), .bitRefused(ssv_if_inst.bitRefused),
      .stackOp(ssv_if_inst.stackOp), .stackPtr(ssv_if_inst.stackPtr),
      .irqTake(ssv_if_inst.irqTake), .irqVector(ssv_if_inst.irqVector),
      .irqAck0(ssv_if_inst.irqAck0), .irqAck1(ssv_if_inst.irqAck1));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      nTests++;
      if (seen !== exp) begin
         errTotal++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One request held across one sampling edge, results settled after it
   task automatic req(input logic w, input logic r, input logic [7:0] a, input logic dm,
                      input logic [7:0] v, input ssv_bit_op_e b, input ssv_stack_op_e so);
      @(posedge clk);
      uWr <= w;
      uRd <= r;
      uAddr <= a;
      uData <= dm;
      uWdata <= v;
      uBitOp <= b;
      uStackOp <= so;
      @(posedge clk);
      uWr <= 1'b0;
      uRd <= 1'b0;
      uBitOp <= BOP_NONE;
      uStackOp <= SOP_NONE;
      #1;
   endtask : req
   // Flag update or bit store, one cycle
   task automatic alu(input logic [4:0] f, input logic ts, input logic tv);
      @(posedge clk);
      uAluWe <= ~ts;
      uAluFlags <= f;
      uTStore <= ts;
      uTValue <= tv;
      @(posedge clk);
      uAluWe <= 1'b0;
      uTStore <= 1'b0;
      #1;
   endtask : alu
   // Bounded wait for an accept; n counts edges waited
   task automatic waitTake();
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (ssv_if_inst.irqTake !== 1'b1 && n < 30);
   endtask : waitTake
   task automatic testDone();
      $display("checks %0d mismatches %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : testDone
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic tRegs();
      chk(10'(statusOut), 10'h000);
      chk(uPc, VEC_RESET);
      req(1, 0, 8'h3F, 0, 8'hFF, BOP_NONE, SOP_NONE);
      req(0, 1, 8'h5F, 1, 8'h00, BOP_NONE, SOP_NONE);
      chk(10'(uRdata), 10'h0EF);
      req(1, 0, 8'h5D, 1, 8'hDF, BOP_NONE, SOP_NONE);
      req(1, 0, 8'h7D, 1, 8'h11, BOP_NONE, SOP_NONE); // Beyond alias: ignored
      req(0, 1, 8'h3D, 0, 8'h00, BOP_NONE, SOP_NONE);
      chk(10'(uRdata), 10'h0DF);
      chk(10'(ssv_if_inst.ioHit), 10'h001);
      req(0, 1, 8'h3E, 0, 8'h00, BOP_NONE, SOP_NONE);
      chk(10'(uRdata), 10'h000);
      $display("registers test done");
   endtask : tRegs
   task automatic tFlags();
      req(1, 0, 8'h3F, 0, 8'h00, BOP_NONE, SOP_NONE);
      alu(5'b10110, 1'b0, 1'b0);
      chk(10'(statusOut), 10'h036);
      alu(5'b00000, 1'b1, 1'b1);
      chk(10'(statusOut), 10'h076);
      chk(10'(uTFlag), 10'h001);
      alu(5'b01100, 1'b0, 1'b0);
      chk(10'(statusOut), 10'h04C);
      $display("flags test done");
   endtask : tFlags
   task automatic tStack();
      ssv_stack_op_e ops[5] = '{SOP_PUSH, SOP_POP, SOP_CALL, SOP_RET, SOP_RETURN_FROM_INTERRUPT};
      logic [7:0] exp[5] = '{8'h7F, 8'h80, 8'h7E, 8'h80, 8'h82};
      req(1, 0, 8'h3D, 0, 8'h80, BOP_NONE, SOP_NONE);
      for (int i = 0; i < 5; i++) begin
         req(0, 0, 8'h00, 0, 8'h00, BOP_NONE, ops[i]);
         chk(10'(ssv_if_inst.stackPtr), 10'(exp[i]));
      end
      chk(10'(statusOut[7]), 10'h001);
      $display("stack test done");
   endtask : tStack
   task automatic tBits();
      @(posedge clk);
      uBitSel <= 3'h5;
      req(0, 0, 8'h10, 0, 8'h00, BOP_SET, SOP_NONE);
      chk(10'(uRdata), 10'h020);
      for (int i = 1; i < 4; i++) begin
         req(0, 0, 8'h1F, 0, 8'h00, ssv_bit_op_e'(i), SOP_NONE);
         chk(10'({ssv_if_inst.bitDone, ssv_if_inst.bitRefused}), 10'h002);
         req(0, 0, 8'h20, 0, 8'h00, ssv_bit_op_e'(i), SOP_NONE);
         chk(10'({ssv_if_inst.bitDone, ssv_if_inst.bitRefused}), 10'h001);
      end
      $display("bit access test done");
   endtask : tBits
   task automatic tIrq();
      req(1, 0, 8'h3D, 0, 8'h80, BOP_NONE, SOP_NONE);
      req(1, 0, 8'h3F, 0, 8'h03, BOP_NONE, SOP_NONE);
      @(posedge clk);
      {extReq, extEn, timerReq, timerEn, uInstrEnd} <= 5'h1F;
      repeat (8) begin
         @(posedge clk);
         #1;
         chk(10'(ssv_if_inst.irqTake), 10'h000);
      end
      req(1, 0, 8'h3F, 0, 8'h83, BOP_NONE, SOP_NONE);
      waitTake();
      // Four pending cycles: the enabling cycle plus three edges
      chk(10'(n >= 3), 10'h001);
      chk(ssv_if_inst.irqVector, VEC_EXT);
      @(posedge clk);
      extReq <= 1'b0; // Flag owner clears the served flag
      uInstrEnd <= 1'b0; // Core mid-instruction: no boundary
      #1;
      chk(uPc, VEC_EXT);
      chk(10'({ssv_if_inst.stackPtr, statusOut[7]}), 10'h0FC);
      chk(10'(statusOut), 10'h003);
      req(0, 0, 8'h00, 0, 8'h00, BOP_NONE, SOP_RETURN_FROM_INTERRUPT);
      repeat (6) begin
         @(posedge clk);
         #1;
         chk(10'(ssv_if_inst.irqTake), 10'h000);
      end
      @(posedge clk);
      uInstrEnd <= 1'b1; // First boundary after return is skipped
      waitTake();
      chk(10'(n), 10'h001);
      chk(ssv_if_inst.irqVector, VEC_TIMER);
      @(posedge clk);
      timerReq <= 1'b0;
      rst <= 1'b1; // Reset in mid-run
      @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(uPc, VEC_RESET);
      chk(10'(statusOut), 10'h000);
      $display("interrupt test done");
   endtask : tIrq
   // ----------------------------------------------------------------
   // Hang guard, ceiling well above the expected run of under a hundred cycles
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errTotal++;
         testDone();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      tRegs();
      tFlags();
      tStack();
      tBits();
      tIrq();
      testDone();
   end
endmodule : tb_status_stack_interrupt_vectoring
